// File: rtl/irq_pin_drive.sv
// Polarity and drive type of the two interrupt pins
`timescale 1ns/1ps
`include "rate_ctrl_consts.svh"
module irq_pin_drive (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  irq_pin_if.pins   pin_if,
  output logic      o_irq_pin_a,
  output logic      o_irq_pin_a_oe,
  output logic      o_irq_pin_b,
  output logic      o_irq_pin_b_oe
);
  logic [1:0] lvl_ff;
  logic [1:0] oe_ff;
  logic [1:0] evt;
  logic [1:0] pol;
  logic [1:0] od;

  assign evt = {pin_if.event_b, pin_if.event_a};
  assign pol = {pin_if.setup[`PIN_B_POL_BIT], pin_if.setup[`PIN_A_POL_BIT]};
  assign od  = {pin_if.setup[`PIN_B_DRIVE_BIT],
                pin_if.setup[`PIN_A_DRIVE_BIT]};

  // ------------------------------------------------------------
  // Pin level and enable per pin
  // ------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        lvl_ff[p] <= 1'b1;
        oe_ff[p]  <= 1'b1;
      end else if (i_ce) begin
        lvl_ff[p] <= evt[p] ~^ pol[p];
        // Open drain drives only the low level
        oe_ff[p]  <= od[p] ? ~(evt[p] ~^ pol[p]) : 1'b1;
      end
    end
  end

  assign o_irq_pin_a    = lvl_ff[0];
  assign o_irq_pin_a_oe = oe_ff[0];
  assign o_irq_pin_b    = lvl_ff[1];
  assign o_irq_pin_b_oe = oe_ff[1];

  a_od_high_release: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && od[0] && (evt[0] ~^ pol[0])) |=> !o_irq_pin_a_oe)
    else $error("open drain pin a driven high");
  a_pol_b_level: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && !od[1]) |=> (o_irq_pin_b == ($past(evt[1]) ~^ $past(pol[1]))))
    else $error("pin b level wrong");
endmodule

// File: rtl/rate_sensor_ctrl_regs.sv
// Control register bank of the rate sensor part
`timescale 1ns/1ps
`include "rate_ctrl_consts.svh"
// How it works
// - Only 0xB6 written to the soft reset register starts a reset.
// - All settings return to reset values 30 ms after the request.
// - Soft reset is accepted in any power mode.
// - Control 0x00 blocks the ready interrupt; 0x80 raises it on new samples.
// - Setup bit 3: pin B push-pull at 0, open drain at 1.
// - Setup bit 2: pin B active low at 0, active high at 1.
// - Setup bit 1: pin A push-pull at 0, open drain at 1.
// - Setup bit 0: pin A active low at 0, active high at 1.
// - Routing 0x00 sends the ready interrupt to no pin.
// - Routing 0x01 sends the ready interrupt to pin A only.
// - Routing 0x80 sends the ready interrupt to pin B only.
// - Routing 0x81 sends the ready interrupt to both pins.
// - Writing 1 to self-test bit 0 starts the built-in test.
// - Self-test bit 1 becomes 1 when the test has finished.
// - Bit 2 reports fail (1) or pass (0) while bit 1 is set.
// - Bit 4 reads 1 when the sensor works properly; resets to 0.
module rate_sensor_ctrl_regs #(
  parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_CYC,
  parameter int unsigned SELF_TEST_CYCLES  = `SELF_TEST_CYC
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire logic                  i_wr_en,
  input  wire logic                  i_rd_en,
  input  wire rate_ctrl_pkg::reg_addr_t i_addr,
  input  wire rate_ctrl_pkg::reg_byte_t i_wdata,
  input  wire logic                  i_new_sample,
  input  wire logic                  i_sensor_ok,
  input  wire logic                  i_test_fail,
  output rate_ctrl_pkg::reg_byte_t   o_rdata,
  output logic                       o_soft_reset_busy,
  output logic                       o_irq_pin_a,
  output logic                       o_irq_pin_a_oe,
  output logic                       o_irq_pin_b,
  output logic                       o_irq_pin_b_oe
);
  import rate_ctrl_pkg::*;

  localparam int unsigned CW = $clog2(SOFT_RESET_CYCLES + 1);
  localparam int unsigned TW = $clog2(SELF_TEST_CYCLES + 1);

  irq_pin_if pin_if ();

  reg_byte_t   irq_ctrl_ff;
  logic [3:0]  pin_setup_ff;
  reg_byte_t   routing_ff;
  logic        health_ff;
  logic        done_ff;
  logic        fail_ff;
  test_state_t test_ff;
  logic [TW-1:0] test_cnt_ff;
  logic        srst_busy_ff;
  logic [CW-1:0] srst_cnt_ff;
  logic        srst_fire;
  logic        wr_srst;
  logic        wr_test;
  logic        sample_irq;
  reg_byte_t   nxt_rdata;
  reg_byte_t   rdata_ff;

  // ----------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------
  assign wr_srst = i_wr_en && (i_addr == `OFS_SOFT_RESET)
                   && (i_wdata == `SOFT_RESET_KEY);
  assign wr_test = i_wr_en && (i_addr == `OFS_SELF_TEST)
                   && i_wdata[`ST_START_BIT];
  assign srst_fire = srst_busy_ff && (srst_cnt_ff == '0);

  // ----------------------------------------------------------
  // Soft reset delay
  // ----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      srst_busy_ff <= 1'b0;
      srst_cnt_ff  <= '0;
    end else if (i_ce) begin
      if (wr_srst && !srst_busy_ff) begin
        srst_busy_ff <= 1'b1;
        srst_cnt_ff  <= CW'(SOFT_RESET_CYCLES - 1);
      end else if (srst_fire) begin
        srst_busy_ff <= 1'b0;
      end else if (srst_busy_ff) begin
        srst_cnt_ff <= srst_cnt_ff - 1'b1;
      end
    end
  end
  assign o_soft_reset_busy = srst_busy_ff;

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      irq_ctrl_ff  <= `RST_IRQ_CTRL;
      pin_setup_ff <= `RST_PIN_SETUP;
      routing_ff   <= `RST_ROUTING;
    end else if (i_ce) begin
      if (srst_fire) begin
        irq_ctrl_ff  <= `RST_IRQ_CTRL;
        pin_setup_ff <= `RST_PIN_SETUP;
        routing_ff   <= `RST_ROUTING;
      end else if (i_wr_en) begin
        case (i_addr)
          `OFS_IRQ_CTRL:  irq_ctrl_ff  <= i_wdata;
          `OFS_PIN_SETUP: pin_setup_ff <= i_wdata[3:0];
          `OFS_ROUTING:   routing_ff   <= i_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Self-test sequencer
  // ----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      test_ff     <= TEST_IDLE;
      test_cnt_ff <= '0;
      done_ff     <= 1'b0;
      fail_ff     <= 1'b0;
    end else if (i_ce) begin
      if (srst_fire) begin
        test_ff <= TEST_IDLE;
        done_ff <= 1'b0;
        fail_ff <= 1'b0;
      end else begin
        case (test_ff)
          TEST_IDLE, TEST_DONE: begin
            if (wr_test) begin
              test_ff     <= TEST_RUN;
              test_cnt_ff <= TW'(SELF_TEST_CYCLES - 1);
              done_ff     <= 1'b0;
              fail_ff     <= 1'b0;
            end
          end
          TEST_RUN: begin
            if (test_cnt_ff == '0) begin
              test_ff <= TEST_DONE;
              done_ff <= 1'b1;
              fail_ff <= i_test_fail;
            end else begin
              test_cnt_ff <= test_cnt_ff - 1'b1;
            end
          end
          default: test_ff <= TEST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Sensor health flag
  // ----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      health_ff <= 1'b0;
    end else if (i_ce) begin
      health_ff <= i_sensor_ok;
    end
  end

  // ----------------------------------------------------------
  // Interrupt enable and routing
  // ----------------------------------------------------------
  assign sample_irq = i_new_sample && (irq_ctrl_ff == `IRQ_CTRL_ON);
  assign pin_if.event_a = sample_irq && ((routing_ff == `ROUTE_A)
                          || (routing_ff == `ROUTE_BOTH));
  assign pin_if.event_b = sample_irq && ((routing_ff == `ROUTE_B)
                          || (routing_ff == `ROUTE_BOTH));
  assign pin_if.setup = pin_setup_ff;

  irq_pin_drive irq_pin_drive_inst (
    .i_clk_sys      (i_clk_sys),
    .i_resetn       (i_resetn),
    .i_ce           (i_ce),
    .pin_if         (pin_if),
    .o_irq_pin_a    (o_irq_pin_a),
    .o_irq_pin_a_oe (o_irq_pin_a_oe),
    .o_irq_pin_b    (o_irq_pin_b),
    .o_irq_pin_b_oe (o_irq_pin_b_oe)
  );

  // ----------------------------------------------------------
  // Read path
  // ----------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    case (i_addr)
      `OFS_SOFT_RESET: nxt_rdata = 8'h00;
      `OFS_IRQ_CTRL:   nxt_rdata = irq_ctrl_ff;
      `OFS_PIN_SETUP:  nxt_rdata = {4'h0, pin_setup_ff};
      `OFS_ROUTING:    nxt_rdata = routing_ff;
      `OFS_SELF_TEST: begin
        nxt_rdata[`ST_HEALTH_BIT] = health_ff;
        nxt_rdata[`ST_FAIL_BIT]   = fail_ff;
        nxt_rdata[`ST_DONE_BIT]   = done_ff;
        nxt_rdata[`ST_START_BIT]  = 1'b0;
      end
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else if (i_ce && i_rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_rdata = rdata_ff;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_key_write;
    i_ce && wr_srst && !srst_busy_ff;
  endsequence

  sequence s_srst_counting;
    i_ce && srst_busy_ff && !srst_fire;
  endsequence

  sequence s_srst_expiry;
    i_ce && srst_fire;
  endsequence

  sequence s_test_resting;
    i_ce && test_ff == TEST_DONE && !wr_test && !srst_fire;
  endsequence

  a_srst_arms_busy: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) s_key_write |=> srst_busy_ff)
    else $error("soft reset not started");
  a_srst_bad_key: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && i_wr_en && i_addr == `OFS_SOFT_RESET
     && i_wdata != `SOFT_RESET_KEY && !srst_busy_ff) |=> !srst_busy_ff)
    else $error("soft reset taken on wrong value");
  a_srst_holds_busy: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) s_srst_counting |=> srst_busy_ff)
    else $error("soft reset ended early");
  a_srst_ends: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) s_srst_expiry |=> !srst_busy_ff)
    else $error("soft reset did not end");
  a_srst_restores: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (i_ce && srst_fire) |=>
    (irq_ctrl_ff == `RST_IRQ_CTRL && routing_ff == `RST_ROUTING
     && pin_setup_ff == `RST_PIN_SETUP && !done_ff))
    else $error("settings not restored");
  a_irq_ctrl_gate: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (irq_ctrl_ff != `IRQ_CTRL_ON)
    |-> !(pin_if.event_a || pin_if.event_b))
    else $error("interrupt while disabled");
  a_route_none: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (routing_ff == `ROUTE_NONE)
    |-> !(pin_if.event_a || pin_if.event_b))
    else $error("event routed with no route");
  a_route_both: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (sample_irq && routing_ff == `ROUTE_BOTH)
    |-> (pin_if.event_a && pin_if.event_b))
    else $error("both route missed a pin");
  a_route_single: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (sample_irq && routing_ff == `ROUTE_A)
    |-> (pin_if.event_a && !pin_if.event_b))
    else $error("pin a route wrong");
  a_route_pin_b: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (sample_irq && routing_ff == `ROUTE_B)
    |-> (!pin_if.event_a && pin_if.event_b))
    else $error("pin b route wrong");
  a_test_done_flag: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && !srst_fire && test_ff == TEST_RUN && test_cnt_ff == '0)
    |=> (done_ff && fail_ff == $past(i_test_fail)))
    else $error("self-test end flags wrong");
  a_test_running: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) (test_ff == TEST_RUN) |-> !done_ff)
    else $error("done flag set while test runs");
  a_test_result_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) s_test_resting |=> (done_ff && $stable(fail_ff)))
    else $error("self-test result changed");
  a_test_start: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && wr_test && !srst_fire && test_ff != TEST_RUN)
    |=> (test_ff == TEST_RUN && !done_ff))
    else $error("self-test did not start");
  a_health_follow: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn) i_ce |=> (health_ff == $past(i_sensor_ok)))
    else $error("health flag does not follow sensor");
  a_wo_reads_zero: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && i_rd_en && i_addr == `OFS_SOFT_RESET) |=> o_rdata == 8'h00)
    else $error("write-only register read nonzero");
  a_test_wo_bit: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    (i_ce && i_rd_en && i_addr == `OFS_SELF_TEST) |=> !o_rdata[`ST_START_BIT])
    else $error("self-test start bit read nonzero");
endmodule

// File: shared/irq_pin_if.sv
// Pin setup bundle between the register bank and the pin driver
`timescale 1ns/1ps
interface irq_pin_if;
  logic event_a;
  logic event_b;
  logic [3:0] setup;
  modport bank (output event_a, output event_b, output setup);
  modport pins (input event_a, input event_b, input setup);
endinterface

// File: shared/rate_ctrl_consts.svh
// Register offsets, field positions, reset values and timing constants
`ifndef RATE_CTRL_CONSTS_SVH
`define RATE_CTRL_CONSTS_SVH
`define OFS_SOFT_RESET   7'h14
`define OFS_IRQ_CTRL     7'h15
`define OFS_PIN_SETUP    7'h16
`define OFS_ROUTING      7'h18
`define OFS_SELF_TEST    7'h3C
`define SOFT_RESET_KEY   8'hB6
`define IRQ_CTRL_OFF     8'h00
`define IRQ_CTRL_ON      8'h80
`define ROUTE_NONE       8'h00
`define ROUTE_A          8'h01
`define ROUTE_B          8'h80
`define ROUTE_BOTH       8'h81
`define RST_IRQ_CTRL     8'h00
`define RST_PIN_SETUP    4'h0
`define RST_ROUTING      8'h00
`define PIN_B_DRIVE_BIT  3
`define PIN_B_POL_BIT    2
`define PIN_A_DRIVE_BIT  1
`define PIN_A_POL_BIT    0
`define ST_HEALTH_BIT    4
`define ST_FAIL_BIT      2
`define ST_DONE_BIT      1
`define ST_START_BIT     0
`define CLK_MHZ          125
`define SOFT_RESET_MS    30
`define SOFT_RESET_CYC   (`SOFT_RESET_MS * 1000 * `CLK_MHZ)
`define SELF_TEST_CYC    64
`endif

// File: shared/rate_ctrl_pkg.sv
// Types shared by the rate sensor control blocks
package rate_ctrl_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [6:0] reg_addr_t;
  typedef enum logic [1:0] {
    TEST_IDLE,
    TEST_RUN,
    TEST_DONE
  } test_state_t;
endpackage

// File: testbench/host_bus_model.sv
// Host model that issues single-byte register writes and reads
`timescale 1ns/1ps
module host_bus_model #(
  parameter int unsigned WAIT_CYC = 250
) (
  input  wire logic                     i_clk_sys,
  input  wire rate_ctrl_pkg::reg_byte_t i_rdata,
  output logic                          o_wr_en,
  output logic                          o_rd_en,
  output rate_ctrl_pkg::reg_addr_t      o_addr,
  output rate_ctrl_pkg::reg_byte_t      o_wdata
);
  import rate_ctrl_pkg::*;

  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 7'h00;
    o_wdata = 8'h00;
  end

  // Write, then stay quiet for the post-write wait (2 us at 125 MHz)
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge i_clk_sys);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk_sys);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    repeat (WAIT_CYC) @(negedge i_clk_sys);
  endtask

  // Read data is taken one cycle after the strobe edge
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    @(negedge i_clk_sys);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clk_sys);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d = i_rdata;
  endtask
endmodule

// File: testbench/rate_sensor_ctrl_regs_test.sv
// Self-checking bench for the rate sensor control register bank
`timescale 1ns/1ps
`include "rate_ctrl_consts.svh"
module rate_sensor_ctrl_regs_test;
  import rate_ctrl_pkg::*;
  logic      clk_sys    = 1'b0;
  logic      resetn     = 1'b0;
  logic      wr_en;
  logic      rd_en;
  reg_addr_t addr;
  reg_byte_t wdata;
  reg_byte_t rdata;
  logic      new_sample = 1'b0;
  logic      sensor_ok  = 1'b0;
  logic      test_fail  = 1'b0;
  logic      busy;
  logic      pin_a;
  logic      pin_a_oe;
  logic      pin_b;
  logic      pin_b_oe;
  int        err_count  = 0;
  int        num_checks = 0;

  always #4 clk_sys = ~clk_sys;

  rate_sensor_ctrl_regs #(
    .SOFT_RESET_CYCLES(400),
    .SELF_TEST_CYCLES (300)
  ) rate_sensor_ctrl_regs_inst (
    .i_clk_sys        (clk_sys),
    .i_resetn         (resetn),
    .i_ce             (1'b1),
    .i_wr_en          (wr_en),
    .i_rd_en          (rd_en),
    .i_addr           (addr),
    .i_wdata          (wdata),
    .i_new_sample     (new_sample),
    .i_sensor_ok      (sensor_ok),
    .i_test_fail      (test_fail),
    .o_rdata          (rdata),
    .o_soft_reset_busy(busy),
    .o_irq_pin_a      (pin_a),
    .o_irq_pin_a_oe   (pin_a_oe),
    .o_irq_pin_b      (pin_b),
    .o_irq_pin_b_oe   (pin_b_oe)
  );

  host_bus_model host_bus_model_inst (
    .i_clk_sys(clk_sys),
    .i_rdata  (rdata),
    .o_wr_en  (wr_en),
    .o_rd_en  (rd_en),
    .o_addr   (addr),
    .o_wdata  (wdata)
  );

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  task automatic chk(input string what, input reg_byte_t got,
                     input reg_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    host_bus_model_inst.wr(a, d);
  endtask

  task automatic rd_chk(input reg_addr_t a, input reg_byte_t m,
                        input reg_byte_t exp);
    reg_byte_t d;
    host_bus_model_inst.rd(a, d);
    chk("register read", d & m, exp);
  endtask

  // One sample pulse (or none), then both pins against setup s
  task automatic pulse(input logic ev, input logic ea, input logic eb,
                       input logic [3:0] s);
    logic la;
    logic lb;
    @(negedge clk_sys);
    new_sample = ev;
    @(negedge clk_sys);
    new_sample = 1'b0;
    la = ~((ev & ea) ^ s[0]);
    lb = ~((ev & eb) ^ s[2]);
    chk("pin a", {7'h00, pin_a}, {7'h00, la});
    chk("pin a oe", {7'h00, pin_a_oe}, {7'h00, ~s[1] | ~la});
    chk("pin b", {7'h00, pin_b}, {7'h00, lb});
    chk("pin b oe", {7'h00, pin_b_oe}, {7'h00, ~s[3] | ~lb});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd_chk(`OFS_SOFT_RESET, 8'hFF, 8'h00);
    rd_chk(`OFS_IRQ_CTRL, 8'hFF, `RST_IRQ_CTRL);
    rd_chk(`OFS_PIN_SETUP, 8'hFF, 8'h00);
    rd_chk(`OFS_ROUTING, 8'hFF, `RST_ROUTING);
    rd_chk(`OFS_SELF_TEST, 8'hFF, 8'h00);
    rd_chk(7'h20, 8'hFF, 8'h00);
    pulse(1'b1, 1'b0, 1'b0, 4'h0);
  endtask

  task automatic test_routing();
    reg_byte_t codes [4] = '{`ROUTE_NONE, `ROUTE_A, `ROUTE_B, `ROUTE_BOTH};
    wr(`OFS_IRQ_CTRL, `IRQ_CTRL_ON);
    foreach (codes[i]) begin
      wr(`OFS_ROUTING, codes[i]);
      rd_chk(`OFS_ROUTING, 8'hFF, codes[i]);
      pulse(1'b1, codes[i][0], codes[i][7], 4'h0);
      pulse(1'b0, codes[i][0], codes[i][7], 4'h0);
    end
    wr(`OFS_IRQ_CTRL, `IRQ_CTRL_OFF);
    pulse(1'b1, 1'b0, 1'b0, 4'h0);
  endtask

  task automatic test_setup();
    wr(`OFS_IRQ_CTRL, `IRQ_CTRL_ON);
    wr(`OFS_ROUTING, `ROUTE_BOTH);
    for (int s = 0; s < 16; s++) begin
      wr(`OFS_PIN_SETUP, 8'(s));
      rd_chk(`OFS_PIN_SETUP, 8'hFF, 8'(s));
      pulse(1'b1, 1'b1, 1'b1, 4'(s));
      pulse(1'b0, 1'b1, 1'b1, 4'(s));
    end
  endtask

  task automatic test_self_test();
    @(negedge clk_sys);
    sensor_ok = 1'b1;
    test_fail = 1'b1;
    wr(`OFS_SELF_TEST, 8'h01);
    rd_chk(`OFS_SELF_TEST, 8'h13, 8'h10);
    repeat (60) @(negedge clk_sys);
    rd_chk(`OFS_SELF_TEST, 8'hFF, 8'h16);
    test_fail = 1'b0;
    wr(`OFS_SELF_TEST, 8'h01);
    rd_chk(`OFS_SELF_TEST, 8'h13, 8'h10);
    repeat (60) @(negedge clk_sys);
    rd_chk(`OFS_SELF_TEST, 8'hFF, 8'h12);
  endtask

  task automatic test_soft_reset();
    wr(`OFS_IRQ_CTRL, `IRQ_CTRL_ON);
    wr(`OFS_ROUTING, `ROUTE_BOTH);
    wr(`OFS_PIN_SETUP, 8'h0F);
    wr(`OFS_SOFT_RESET, 8'h55);
    chk("reset busy", {7'h00, busy}, 8'h00);
    rd_chk(`OFS_ROUTING, 8'hFF, `ROUTE_BOTH);
    wr(`OFS_SOFT_RESET, `SOFT_RESET_KEY);
    chk("reset busy", {7'h00, busy}, 8'h01);
    repeat (140) @(negedge clk_sys);
    chk("reset busy", {7'h00, busy}, 8'h01);
    repeat (20) @(negedge clk_sys);
    chk("reset busy", {7'h00, busy}, 8'h00);
    rd_chk(`OFS_IRQ_CTRL, 8'hFF, `RST_IRQ_CTRL);
    rd_chk(`OFS_PIN_SETUP, 8'hFF, 8'h00);
    rd_chk(`OFS_ROUTING, 8'hFF, `RST_ROUTING);
    rd_chk(`OFS_SELF_TEST, 8'h06, 8'h00);
    pulse(1'b1, 1'b0, 1'b0, 4'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    test_reset();
    test_routing();
    test_setup();
    test_self_test();
    test_soft_reset();
    summarize();
  end
endmodule
